// >>> fbwp_pkg.sv
// Purpose: Shared constants for the flash block write protection logic
// Assumes: Serial bus sampled by clk_in; APB register access
// Notes:   Opcodes, register offsets, status bit positions and reset values
`default_nettype none

package fbwp_pkg;

  // ----------------------------------------
  // Serial opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG     = 8'h32;
  localparam logic [7:0] OP_SECT_ERASE_A  = 8'h20;
  localparam logic [7:0] OP_SECT_ERASE_B  = 8'hd7;
  localparam logic [7:0] OP_BLK32_ERASE   = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE   = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'h60;
  localparam logic [7:0] OP_PARAM_VOL_NW  = 8'hc0;
  localparam logic [7:0] OP_PARAM_VOL_WE  = 8'h63;
  localparam logic [7:0] OP_BANK_VOL_NW   = 8'h17;
  localparam logic [7:0] OP_BANK_VOL_WE   = 8'hc5;

  // ----------------------------------------
  // Operation kinds handed to the array
  // ----------------------------------------
  typedef enum logic [2:0] {
    FBWP_OP_PROG  = 3'b000,
    FBWP_OP_SECT  = 3'b001,
    FBWP_OP_BLK32 = 3'b010,
    FBWP_OP_BLK64 = 3'b011,
    FBWP_OP_CHIP  = 3'b100
  } fbwp_op_t;

  // ----------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------
  localparam int         SR_LATCH_POS  = 1;
  localparam int         SR_BP_LSB     = 2;
  localparam int         SR_QUAD_POS   = 6;
  localparam int         SR_LOCK_POS   = 7;
  localparam logic [5:0] SR_NV_RESET   = 6'h00;
  localparam logic       SIDE_RESET    = 1'b0;
  localparam logic [7:0] VOL_RESET     = 8'h00;
  localparam int         ADDR_BYTES    = 3;

  // ----------------------------------------
  // APB register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_FUNC      = 8'h04;
  localparam logic [7:0] REG_VOLATILE  = 8'h08;
  localparam logic [7:0] REG_LAST_OP   = 8'h0c;
  localparam int         FUNC_SIDE_POS = 1;
  localparam int         LAST_REJ_POS  = 31;

endpackage : fbwp_pkg

`default_nettype wire

// >>> fbwp_top.sv
// Purpose: Block write protection and status register gate of a serial flash
// Assumes: Serial pins asynchronous to clk_in; array core executes issued ops
// Notes:   Serial clock is oversampled; mode 0 framing by chip select
//
// Summary of operation
// [RULE1] C0h and 17h need no write enable
// [RULE2] Program or erase in protected region refused
// [RULE3] Chip erase only when protect code zero
// [RULE4] Disable bit clear: status writes always allowed
// [RULE5] Disable set, protect pin low: writes ignored
// [RULE6] Disable set, protect pin high: writes allowed
// [RULE7] Quad bit zero: pins keep control functions
// [RULE8] Quad bit one: pins are data lines
// [RULE9] 64KB codes 1-10 protect powers of two
// [RULE10] 64KB codes 11-15 protect 768..1024 blocks
// [RULE11] Selector zero top down, one bottom up
// [RULE12] 256KB codes 1-8 protect powers of two
// [RULE13] 256KB codes 9-15 protect all blocks
// [RULE14] Selector is set-only, never back to top
// [RULE15] Host sends write enable before writes
// [RULE16] Overlapping erase rejected as a whole
`timescale 1ns/100ps
`default_nettype none

module fbwp_top #(
  parameter int ADDR_W       = 26,
  parameter bit LARGE_BLOCKS = 1'b0
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  // APB slave
  input  wire logic [7:0]        paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Serial link
  input  wire logic              sck_in,
  input  wire logic              cs_n_in,
  input  wire logic              si_in,
  input  wire logic              so_in,
  output logic                   so_out,
  output logic                   so_oe_out,
  input  wire logic              data_line_two_in,
  output logic                   data_line_two_out,
  output logic                   data_line_two_oe_out,
  input  wire logic              data_line_three_in,
  output logic                   data_line_three_out,
  output logic                   data_line_three_oe_out,
  // Array core
  input  wire logic              core_busy_in,
  output logic                   op_valid_out,
  output logic      [2:0]        op_kind_out,
  output logic      [ADDR_W-1:0] op_addr_out,
  output logic                   op_reject_out,
  output logic                   prog_byte_valid_out,
  output logic      [7:0]        prog_byte_out,
  output logic                   hold_active_out
);

  typedef enum logic [2:0] {
    ST_CMD  = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b011,
    ST_SKIP = 3'b100
  } fbwp_state_t;

  localparam int NBLK_W = 11;
  localparam logic [NBLK_W-1:0] NBLK = LARGE_BLOCKS ? 11'd256 : 11'd1024;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic       sck_d_r;
  logic       cs_d_r;
  logic       sck_s1_r;
  logic       sck_s2_r;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_s1_r <= 5'h1f;
      pin_s2_r <= 5'h1f;
      sck_d_r  <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      pin_s1_r <= {data_line_three_in, data_line_two_in, so_in, si_in, cs_n_in};
      pin_s2_r <= pin_s1_r;
      sck_d_r  <= sck_s2_r;
      cs_d_r   <= pin_s2_r[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
    end else begin
      sck_s1_r <= sck_in;
      sck_s2_r <= sck_s1_r;
    end
  end

  // ----------------------------------------
  // Status, function and volatile state
  // ----------------------------------------
  logic [5:0]        sr_nv_r;
  logic              write_enable_latch_r;
  logic              top_bottom_select_r;
  logic [7:0]        vol_param_r;
  logic [7:0]        vol_bank_r;
  logic              last_rej_r;
  logic [2:0]        last_kind_r;
  logic [ADDR_W-1:0] last_addr_r;

  logic       quad_enable_bit;
  logic       status_write_disable;
  logic [3:0] bp;
  assign quad_enable_bit      = sr_nv_r[fbwp_pkg::SR_QUAD_POS - fbwp_pkg::SR_BP_LSB];
  assign status_write_disable = sr_nv_r[fbwp_pkg::SR_LOCK_POS - fbwp_pkg::SR_BP_LSB];
  assign bp                   = sr_nv_r[3:0];

  // [RULE7] Control pin functions
  logic wp_low;
  logic hold_act;
  assign wp_low   = ~quad_enable_bit & ~pin_s2_r[3];
  assign hold_act = ~quad_enable_bit & ~pin_s2_r[4] & ~pin_s2_r[0];
  assign hold_active_out = hold_act;

  logic active;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  assign active   = ~pin_s2_r[0];
  assign sck_rise = sck_s2_r & ~sck_d_r & active & ~hold_act;
  assign sck_fall = ~sck_s2_r & sck_d_r & active & ~hold_act;
  assign cs_rise  = pin_s2_r[0] & ~cs_d_r;

  // ----------------------------------------
  // Protected range decode
  // ----------------------------------------
  function automatic logic [NBLK_W-1:0] prot_count(input logic [3:0] code);
    logic [NBLK_W-1:0] n;
    n = '0;
    if (code == 4'h0) begin
      n = '0;
    end else if (LARGE_BLOCKS) begin
      // [RULE12] Doubling up to 128
      // [RULE13] Nine and above: all
      n = (code > 4'h8) ? 11'd256 : (11'd1 << (code - 4'h1));
    end else if (code <= 4'ha) begin
      // [RULE9] Doubling up to 512
      n = 11'd1 << (code - 4'h1);
    end else begin
      // [RULE10] Upper code counts
      case (code)
        4'hb:    n = 11'd768;
        4'hc:    n = 11'd896;
        4'hd:    n = 11'd960;
        4'he:    n = 11'd992;
        default: n = 11'd1024;
      endcase
    end
    return n;
  endfunction : prot_count

  logic [ADDR_W-1:0] addr_r;
  logic [NBLK_W-1:0] blk;
  logic [NBLK_W-1:0] pcnt;
  logic              in_prot;
  assign blk  = LARGE_BLOCKS ? NBLK_W'(addr_r[ADDR_W-1:18]) : NBLK_W'(addr_r[ADDR_W-1:16]);
  assign pcnt = prot_count(bp);
  // [RULE11] Top down or bottom up
  // [RULE16] Erases sit in one block
  assign in_prot = top_bottom_select_r ? (blk < pcnt) : (blk >= NBLK - pcnt);

  // ----------------------------------------
  // Serial command framing
  // ----------------------------------------
  fbwp_state_t state_r;
  logic [7:0]  opcode_r;
  logic [7:0]  shift_r;
  logic [2:0]  bitcnt_r;
  logic [1:0]  abytes_r;
  logic        got_data_r;
  logic [7:0]  data_r;
  logic        quad_r;
  logic [7:0]  so_shift_r;
  logic [7:0]  nbyte;
  logic        byte_done;
  logic [7:0]  status_byte;

  assign status_byte = {sr_nv_r, write_enable_latch_r, core_busy_in};
  // [RULE8] Four data lines in quad
  assign nbyte = quad_r ? {shift_r[3:0], pin_s2_r[4:1]} : {shift_r[6:0], pin_s2_r[1]};
  assign byte_done = sck_rise && (quad_r ? (bitcnt_r == 3'd1) : (bitcnt_r == 3'd7));

  logic is_prog;
  logic is_erase;
  assign is_prog  = (opcode_r == fbwp_pkg::OP_PAGE_PROG) || (opcode_r == fbwp_pkg::OP_QUAD_PROG);
  assign is_erase = (opcode_r == fbwp_pkg::OP_SECT_ERASE_A) ||
                    (opcode_r == fbwp_pkg::OP_SECT_ERASE_B) ||
                    (opcode_r == fbwp_pkg::OP_BLK32_ERASE) ||
                    (opcode_r == fbwp_pkg::OP_BLK64_ERASE);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r    <= ST_CMD;
      opcode_r   <= 8'h00;
      shift_r    <= 8'h00;
      bitcnt_r   <= 3'd0;
      abytes_r   <= 2'd0;
      got_data_r <= 1'b0;
      data_r     <= 8'h00;
      quad_r     <= 1'b0;
      addr_r     <= '0;
    end else if (cs_rise || !active) begin
      state_r    <= ST_CMD;
      bitcnt_r   <= 3'd0;
      quad_r     <= 1'b0;
      if (cs_rise) begin
        abytes_r   <= 2'd0;
        got_data_r <= 1'b0;
        opcode_r   <= 8'h00;
      end
    end else if (sck_rise) begin
      shift_r  <= nbyte;
      bitcnt_r <= byte_done ? 3'd0 : bitcnt_r + 3'd1;
      if (byte_done) begin
        case (state_r)
          ST_CMD: begin
            opcode_r <= nbyte;
            if (core_busy_in && nbyte != fbwp_pkg::OP_STATUS_READ) begin
              state_r <= ST_SKIP;
            end else if (nbyte == fbwp_pkg::OP_STATUS_READ) begin
              state_r <= ST_READ;
            end else if (nbyte == fbwp_pkg::OP_PAGE_PROG || nbyte == fbwp_pkg::OP_QUAD_PROG ||
                         nbyte == fbwp_pkg::OP_SECT_ERASE_A || nbyte == fbwp_pkg::OP_SECT_ERASE_B ||
                         nbyte == fbwp_pkg::OP_BLK32_ERASE || nbyte == fbwp_pkg::OP_BLK64_ERASE) begin
              state_r <= ST_ADDR;
            end else if (nbyte == fbwp_pkg::OP_STATUS_WRITE ||
                         nbyte == fbwp_pkg::OP_PARAM_VOL_NW || nbyte == fbwp_pkg::OP_PARAM_VOL_WE ||
                         nbyte == fbwp_pkg::OP_BANK_VOL_NW || nbyte == fbwp_pkg::OP_BANK_VOL_WE) begin
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_SKIP;
            end
          end
          ST_ADDR: begin
            addr_r   <= ADDR_W'({addr_r, nbyte});
            abytes_r <= abytes_r + 2'd1;
            if (abytes_r == 2'(fbwp_pkg::ADDR_BYTES - 1)) begin
              // Bank bits extend the three address bytes
              addr_r  <= ADDR_W'({vol_bank_r[1:0], addr_r[15:0], nbyte});
              state_r <= is_prog ? ST_DATA : ST_SKIP;
              quad_r  <= quad_enable_bit && (opcode_r == fbwp_pkg::OP_QUAD_PROG);
            end
          end
          ST_DATA: begin
            if (!got_data_r) begin
              data_r <= nbyte;
            end
            got_data_r <= 1'b1;
          end
          default: state_r <= state_r;
        endcase
      end
    end
  end

  // Status read out on the falling edge
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      so_shift_r <= 8'h00;
      so_out     <= 1'b0;
      so_oe_out  <= 1'b0;
    end else begin
      so_oe_out <= active && (state_r == ST_READ);
      if (sck_fall && state_r == ST_READ) begin
        so_out     <= (bitcnt_r == 3'd1) ? status_byte[7] : so_shift_r[7];
        so_shift_r <= (bitcnt_r == 3'd1) ? {status_byte[6:0], 1'b0} : {so_shift_r[6:0], 1'b0};
      end
    end
  end

  assign data_line_two_out      = 1'b0;
  assign data_line_two_oe_out   = 1'b0;
  assign data_line_three_out    = 1'b0;
  assign data_line_three_oe_out = 1'b0;

  // ----------------------------------------
  // Program data stream
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prog_byte_valid_out <= 1'b0;
      prog_byte_out       <= 8'h00;
    end else begin
      // [RULE2] Protected data dropped
      prog_byte_valid_out <= byte_done && state_r == ST_DATA && is_prog &&
                             write_enable_latch_r && !in_prot;
      if (byte_done) begin
        prog_byte_out <= nbyte;
      end
    end
  end

  // ----------------------------------------
  // Execution at end of frame
  // ----------------------------------------
  logic [2:0] op_kind;
  always_comb begin
    case (opcode_r)
      fbwp_pkg::OP_SECT_ERASE_A: op_kind = fbwp_pkg::FBWP_OP_SECT;
      fbwp_pkg::OP_SECT_ERASE_B: op_kind = fbwp_pkg::FBWP_OP_SECT;
      fbwp_pkg::OP_BLK32_ERASE:  op_kind = fbwp_pkg::FBWP_OP_BLK32;
      fbwp_pkg::OP_BLK64_ERASE:  op_kind = fbwp_pkg::FBWP_OP_BLK64;
      default:                   op_kind = fbwp_pkg::FBWP_OP_PROG;
    endcase
  end

  logic frame_ok;
  logic sr_writable;
  logic addr_done;
  assign frame_ok  = cs_rise && (bitcnt_r == 3'd0);
  assign addr_done = (abytes_r == 2'(fbwp_pkg::ADDR_BYTES));
  // [RULE4] Disable clear: writable
  // [RULE5] Disable set, pin low: locked
  // [RULE6] Disable set, pin high: writable
  assign sr_writable = ~status_write_disable | ~wp_low;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sr_nv_r       <= fbwp_pkg::SR_NV_RESET;
      write_enable_latch_r <= 1'b0;
      vol_param_r   <= fbwp_pkg::VOL_RESET;
      vol_bank_r    <= fbwp_pkg::VOL_RESET;
      op_valid_out  <= 1'b0;
      op_reject_out <= 1'b0;
      op_kind_out   <= fbwp_pkg::FBWP_OP_PROG;
      op_addr_out   <= '0;
      last_rej_r    <= 1'b0;
      last_kind_r   <= fbwp_pkg::FBWP_OP_PROG;
      last_addr_r   <= '0;
    end else begin
      op_valid_out  <= 1'b0;
      op_reject_out <= 1'b0;
      if (frame_ok && !(core_busy_in && opcode_r != fbwp_pkg::OP_STATUS_READ)) begin
        case (opcode_r)
          fbwp_pkg::OP_WRITE_ENABLE:  write_enable_latch_r <= 1'b1;
          fbwp_pkg::OP_WRITE_DISABLE: write_enable_latch_r <= 1'b0;
          fbwp_pkg::OP_STATUS_WRITE: begin
            // [RULE15] Latch must be set
            if (write_enable_latch_r && got_data_r && sr_writable) begin
              sr_nv_r              <= data_r[7:2];
              write_enable_latch_r <= 1'b0;
            end
          end
          // [RULE1] No latch needed for C0h and 17h
          fbwp_pkg::OP_PARAM_VOL_NW: if (got_data_r) vol_param_r <= data_r;
          fbwp_pkg::OP_BANK_VOL_NW:  if (got_data_r) vol_bank_r <= data_r;
          fbwp_pkg::OP_PARAM_VOL_WE: if (got_data_r && write_enable_latch_r) vol_param_r <= data_r;
          fbwp_pkg::OP_BANK_VOL_WE:  if (got_data_r && write_enable_latch_r) vol_bank_r <= data_r;
          fbwp_pkg::OP_CHIP_ERASE_A, fbwp_pkg::OP_CHIP_ERASE_B: begin
            if (write_enable_latch_r) begin
              // [RULE3] Only with zero code
              op_valid_out  <= (bp == 4'h0);
              op_reject_out <= (bp != 4'h0);
              op_kind_out   <= fbwp_pkg::FBWP_OP_CHIP;
              op_addr_out   <= '0;
              last_rej_r    <= (bp != 4'h0);
              last_kind_r   <= fbwp_pkg::FBWP_OP_CHIP;
              last_addr_r   <= '0;
              write_enable_latch_r <= 1'b0;
            end
          end
          default: begin
            if (write_enable_latch_r && addr_done && (is_erase || (is_prog && got_data_r))) begin
              // [RULE2] Refuse protected target
              // [RULE16] Whole erase rejected
              op_valid_out  <= !in_prot;
              op_reject_out <= in_prot;
              op_kind_out   <= op_kind;
              op_addr_out   <= addr_r;
              last_rej_r    <= in_prot;
              last_kind_r   <= op_kind;
              last_addr_r   <= addr_r;
              write_enable_latch_r <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic setup;
  assign setup      = psel_in && !penable_in;
  assign pready_out = 1'b1;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      top_bottom_select_r <= fbwp_pkg::SIDE_RESET;
    end else if (psel_in && penable_in && pwrite_in && paddr_in == fbwp_pkg::REG_FUNC) begin
      // [RULE14] Selector only sets
      top_bottom_select_r <= top_bottom_select_r | pwdata_in[fbwp_pkg::FUNC_SIDE_POS];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      if (paddr_in == fbwp_pkg::REG_STATUS) begin
        prdata_out <= {24'h00_0000, status_byte};
      end else if (paddr_in == fbwp_pkg::REG_FUNC) begin
        prdata_out <= 32'(top_bottom_select_r) << fbwp_pkg::FUNC_SIDE_POS;
      end else if (paddr_in == fbwp_pkg::REG_VOLATILE) begin
        prdata_out <= {16'h0000, vol_bank_r, vol_param_r};
      end else if (paddr_in == fbwp_pkg::REG_LAST_OP) begin
        prdata_out <= {last_rej_r, 2'b00, last_kind_r, 26'(last_addr_r)};
      end else begin
        pslverr_out <= 1'b1;
      end
    end
  end

endmodule : fbwp_top

`default_nettype wire

// >>> fbwp_asserts.sv
// Purpose: Port-level checks of the block write protection logic
// Assumes: Bound to fbwp_top; one clock domain
// Notes:   Sees only top-level ports
`timescale 1ns/100ps
`default_nettype none

module fbwp_asserts (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       nrst_in,
  // Link pins
  input wire logic       cs_n_in,
  input wire logic       data_line_three_in,
  input wire logic       so_oe_out,
  input wire logic       data_line_two_oe_out,
  input wire logic       hold_active_out,
  // Array side
  input wire logic       op_valid_out,
  input wire logic       op_reject_out,
  input wire logic [2:0] op_kind_out,
  input wire logic       prog_byte_valid_out
);
  logic [3:0] since_cs_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Cycles since chip select was last low
  always_ff @(posedge clk_in) begin
    if (!nrst_in) since_cs_r <= 4'hf;
    else if (!cs_n_in) since_cs_r <= 4'h0;
    else if (since_cs_r != 4'hf) since_cs_r <= since_cs_r + 4'h1;
  end

  op_excl_a: assert property (!(op_valid_out && op_reject_out))
    else $error("accept and refuse together");
  op_timing_a: assert property ((op_valid_out || op_reject_out) |->
    (since_cs_r >= 4'h1 && since_cs_r <= 4'ha)) else $error("outcome not after frame end");
  valid_pulse_a: assert property (op_valid_out |=> !op_valid_out)
    else $error("accept pulse too long");
  reject_pulse_a: assert property (op_reject_out |=> !op_reject_out)
    else $error("refuse pulse too long");
  kind_hold_a: assert property ($changed(op_kind_out) |-> (op_valid_out || op_reject_out))
    else $error("kind changed without operation");
  reject_data_a: assert property (op_reject_out |-> (!prog_byte_valid_out)[*8])
    else $error("data forwarded for refused program");
  wp_input_a: assert property (!data_line_two_oe_out)
    else $error("protect pin driven");
  hold_pin_a: assert property (hold_active_out |-> $past(!data_line_three_in, 2))
    else $error("hold without hold pin low");
  so_idle_a: assert property (cs_n_in[*4] |-> !so_oe_out)
    else $error("data line driven outside frame");
  cover property (op_reject_out);
endmodule : fbwp_asserts

bind fbwp_top fbwp_asserts i_chk (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in),
  .data_line_three_in(data_line_three_in), .so_oe_out(so_oe_out),
  .data_line_two_oe_out(data_line_two_oe_out), .hold_active_out(hold_active_out),
  .op_valid_out(op_valid_out), .op_reject_out(op_reject_out), .op_kind_out(op_kind_out),
  .prog_byte_valid_out(prog_byte_valid_out));

`default_nettype wire

// >>> fbwp_host.sv
// Purpose: Serial host model driving the link in mode 0
// Assumes: 160 ns link clock, idle low, only inside frames
// Notes:   Data line released between frames shows the inverse level
`timescale 1ns/100ps
`default_nettype none

module fbwp_host (
  // Link pins
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  output logic wp_n_out,
  output logic hold_n_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    wp_n_out = 1'b1;
    hold_n_out = 1'b1;
  end

  // Send the top nbytes of d, most significant bit first
  task automatic xfer(input logic [39:0] d, input int nbytes);
    #3 cs_n_out = 1'b0;
    #40;
    for (int i = 0; i < nbytes * 8; i++) begin
      si_out = d[39-i];
      #80 sck_out = 1'b1;
      #80 sck_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    si_out = ~si_out;
    #400;
  endtask : xfer

  task automatic write_enable_cmd();
    xfer({8'h06, 32'h0}, 1);
  endtask : write_enable_cmd
endmodule : fbwp_host

`default_nettype wire

// >>> tb_flash_block_write_protection.sv
// Purpose: Self-checking bench for the block write protection logic
// Assumes: 64KB geometry; bank bits 1:0 extend the address to 26 bits
// Notes:   Host model drives the link; APB tasks reach the registers
`timescale 1ns/100ps
`default_nettype none

module tb_flash_block_write_protection;
  logic        clk_in, nrst_in, psel, pen, pwr, pready, pslverr, so, so_oe, ov, orj, pbv;
  logic        sck, cs_n, si, wp_n, hold_n, hact, e;
  logic [7:0]  paddr, pb;
  logic [31:0] pwdata, prdata, r;
  int          fail_count, check_count, nv, nr, nb;

  fbwp_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .so_in(so_oe ? so : ~sck), .so_out(so), .so_oe_out(so_oe), .data_line_two_in(wp_n),
    .data_line_two_out(), .data_line_two_oe_out(), .data_line_three_in(hold_n),
    .data_line_three_out(), .data_line_three_oe_out(), .core_busy_in(1'b0),
    .op_valid_out(ov), .op_kind_out(), .op_addr_out(), .op_reject_out(orj),
    .prog_byte_valid_out(pbv), .prog_byte_out(pb), .hold_active_out(hact));
  fbwp_host i_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .wp_n_out(wp_n),
    .hold_n_out(hold_n));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (ov === 1'b1) nv++;
    if (orj === 1'b1) nr++;
    if (pbv === 1'b1) nb++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd

  task automatic sr(input logic [7:0] v);
    i_host.write_enable_cmd();
    i_host.xfer({8'h01, v, 24'h0}, 2);
  endtask : sr

  task automatic op(input logic [7:0] code, input logic [9:0] blk, input int n,
                    input int ev, input int er);
    i_host.xfer({8'h17, 6'h00, blk[9:8], 24'h0}, 2);
    nv = 0;
    nr = 0;
    nb = 0;
    i_host.write_enable_cmd();
    i_host.xfer({code, blk[7:0], 16'h0, 8'h5a}, n);
    chk(nv, ev);
    chk(nr, er);
  endtask : op

  function automatic int nblk(input int c);
    if (c < 11) return (c == 0) ? 0 : (1 << (c - 1));
    if (c < 15) return 1024 - (256 >> (c - 11));
    return 1024;
  endfunction : nblk

  task automatic t_regs();
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h0c, 32'h0);
    apb(1'b1, 8'h00, 32'hff);
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    chk(e, 1'b1);
    i_host.xfer({8'hc0, 8'h2c, 24'h0}, 2);
    i_host.xfer({8'h17, 8'h01, 24'h0}, 2);
    i_host.xfer({8'h63, 8'h11, 24'h0}, 2);
    rd(8'h08, 32'h0000_012c);
    nv = 0;
    nr = 0;
    i_host.xfer({8'h20, 32'h0}, 4);
    i_host.xfer({8'h01, 8'h3c, 24'h0}, 2);
    chk(nv + nr, 0);
    rd(8'h00, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_top();
    for (int c = 1; c < 16; c++) begin
      sr(8'(c << 2));
      rd(8'h00, 32'(c << 2));
      op(8'hd8, 10'(1024 - nblk(c)), 4, 0, 1);
      if (c < 15) op(8'hd8, 10'(1023 - nblk(c)), 4, 1, 0);
    end
    op(8'hc7, 10'h0, 1, 0, 1);
    sr(8'h04);
    op(8'h02, 10'h3ff, 5, 0, 1);
    chk(nb, 0);
    rd(8'h0c, 32'h83ff_0000);
    op(8'h02, 10'h3fe, 5, 1, 0);
    chk(pb, 8'h5a);
    sr(8'h00);
    op(8'hc7, 10'h0, 1, 1, 0);
    rd(8'h0c, 32'h1000_0000);
    $display("test top done");
  endtask : t_top

  task automatic t_bottom();
    int cl[4] = '{1, 10, 11, 14};
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h04, 32'h0);
    rd(8'h04, 32'h2);
    for (int i = 0; i < 4; i++) begin
      sr(8'(cl[i] << 2));
      op(8'h20, 10'(nblk(cl[i]) - 1), 4, 0, 1);
      op(8'h52, 10'(nblk(cl[i])), 4, 1, 0);
    end
    $display("test bottom done");
  endtask : t_bottom

  task automatic t_lock();
    sr(8'h84);
    i_host.wp_n_out <= 1'b0;
    sr(8'h08);
    rd(8'h00, 32'h86);
    i_host.wp_n_out <= 1'b1;
    sr(8'h88);
    rd(8'h00, 32'h88);
    sr(8'h00);
    i_host.wp_n_out <= 1'b0;
    sr(8'h04);
    rd(8'h00, 32'h04);
    i_host.hold_n_out <= 1'b0;
    i_host.cs_n_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(hact, 1'b1);
    i_host.cs_n_out <= 1'b1;
    i_host.hold_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    sr(8'hc0);
    sr(8'hc0);
    sr(8'hc8);
    rd(8'h00, 32'hc8);
    i_host.hold_n_out <= 1'b0;
    i_host.cs_n_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(hact, 1'b0);
    i_host.cs_n_out <= 1'b1;
    i_host.hold_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    $display("test lock done");
  endtask : t_lock

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    #720_000;
    fail_count++;
    wrap_up();
  end

  initial begin
    nrst_in = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_regs();
    t_top();
    t_bottom();
    t_lock();
    wrap_up();
  end
endmodule : tb_flash_block_write_protection

`default_nettype wire
